/* inc/hscs_pkg.sv */
// Purpose: shared constants for the hub strap and configuration-source selector
// Assumes: 200 MHz clock, APB register access with 32-bit data
// Notes: register offsets are byte addresses, one aligned word each
package hscs_pkg;

  // clock and reset timing
  localparam int CLK_MHZ = 200;
  localparam int RST_MIN_PULSE_NS = 1000;
  localparam int RST_MIN_PULSE_CYC = (RST_MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int POR_SETTLE_CYC = 16;
  localparam logic [4:0] POR_CNT_DONE = 5'(POR_SETTLE_CYC);

  // configuration source select encodings {hi, lo}
  localparam logic [1:0] SRC_DEFAULT = 2'h0;
  localparam logic [1:0] SRC_SMBUS = 2'h1;
  localparam logic [1:0] SRC_DEFAULT_BUSPWR = 2'h2;
  localparam logic [1:0] SRC_EEPROM = 2'h3;

  // smbus slave address, 7-bit form of 0101100
  localparam logic [6:0] SMBUS_SLAVE_ADDR = 7'h2c;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PORTS = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // control register fields
  localparam int CTRL_CONFIGURED = 0;
  localparam int CTRL_SUSPENDED = 1;
  localparam int CTRL_HIGH_SPEED = 2;
  localparam int CTRL_LED_DRIVE = 3;
  localparam int CTRL_LED_ACT_LOW = 4;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RESET = 5'h08;

  // ports register: non-removable mask from software
  localparam int PORTS_W = 2;
  localparam logic [1:0] PORTS_RESET = 2'h0;

  // status register fields
  localparam int STAT_SRC_LSB = 0;
  localparam int STAT_STRAP_LSB = 2;
  localparam int STAT_STRAPS_EN = 4;
  localparam int STAT_BUS_POWERED = 5;
  localparam int STAT_SELF_POWER = 6;
  localparam int STAT_FIXED_LSB = 7;
  localparam int STAT_CFG_DONE = 9;
  localparam int STAT_SMB_ADDR_LSB = 10;

  typedef enum logic [1:0] {
    HSCS_ST_HOLD,
    HSCS_ST_SETTLE,
    HSCS_ST_SAMPLE,
    HSCS_ST_RUN
  } hscs_state_e;

endpackage

/* src/hscs_top.sv */
// Purpose: reset-time configuration source selection and strap sampling
// Assumes: all inputs synchronous to clk; nrst asynchronous, active low
// Notes: shared pins are split into input, output and output enable
`timescale 1ns/1ps

module hscs_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic supply_good,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // shared pins
  input wire logic cfg_source_sel_lo,
  input wire logic cfg_source_sel_hi_in,
  output logic high_speed_led_out,
  output logic high_speed_led_oe,
  input wire logic activity_led_in,
  output logic activity_led_out,
  output logic activity_led_oe,
  input wire logic fixed_port_strap_hi,
  // results toward the hub core
  output logic core_rst_n,
  output logic cfg_done,
  output logic [1:0] cfg_source,
  output logic straps_en,
  output logic smbus_slave_en,
  output logic [6:0] smbus_slave_addr,
  output logic eeprom_load_en,
  output logic bus_powered,
  output logic self_power,
  output logic [1:0] fixed_ports
);

  hscs_pkg::hscs_state_e state_r;
  logic [4:0] por_cnt_r;
  logic core_rst_n_r;
  logic [1:0] src_r;
  logic [1:0] strap_r;
  logic cfg_done_r;
  logic self_power_r;
  logic [hscs_pkg::CTRL_W-1:0] ctrl_r;
  logic [hscs_pkg::PORTS_W-1:0] ports_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic hs_led_r;
  logic hs_oe_r;
  logic act_led_r;
  logic act_oe_r;
  logic straps_en_r;
  logic smbus_en_r;
  logic eeprom_en_r;
  logic bus_powered_r;
  logic [1:0] fixed_r;
  logic straps_en_nxt;
  logic [1:0] fixed_nxt;
  logic act_low_nxt;
  logic bus_powered_nxt;
  logic [31:0] status_w;
  logic setup_w;
  logic access_w;

  // straps count only in the two built-in default modes
  function automatic logic src_uses_straps(input logic [1:0] src);
    return (src == hscs_pkg::SRC_DEFAULT) || (src == hscs_pkg::SRC_DEFAULT_BUSPWR);
  endfunction

  // strap decode: bit1 fixes both ports, else bit0 fixes port 1
  function automatic logic [1:0] strap_fixed(input logic [1:0] strap);
    return strap[1] ? 2'h3 : {1'b0, strap[0]};
  endfunction

  // power-on settle and reset release sequence
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= hscs_pkg::HSCS_ST_HOLD;
      por_cnt_r <= 5'h00;
      core_rst_n_r <= 1'b0;
    end else begin
      case (state_r)
        hscs_pkg::HSCS_ST_HOLD: begin
          core_rst_n_r <= 1'b0;
          por_cnt_r <= 5'h00;
          if (supply_good) begin
            state_r <= hscs_pkg::HSCS_ST_SETTLE;
          end
        end
        hscs_pkg::HSCS_ST_SETTLE: begin
          if (!supply_good) begin
            state_r <= hscs_pkg::HSCS_ST_HOLD;
            por_cnt_r <= 5'h00;
          end else if (por_cnt_r == hscs_pkg::POR_CNT_DONE) begin
            state_r <= hscs_pkg::HSCS_ST_SAMPLE;
          end else begin
            por_cnt_r <= por_cnt_r + 5'h01;
          end
        end
        hscs_pkg::HSCS_ST_SAMPLE: begin
          core_rst_n_r <= 1'b1;
          state_r <= hscs_pkg::HSCS_ST_RUN;
        end
        hscs_pkg::HSCS_ST_RUN: begin
          // supply loss drops the core back into reset
          if (!supply_good) begin
            state_r <= hscs_pkg::HSCS_ST_HOLD;
            core_rst_n_r <= 1'b0;
          end
        end
        default: begin
          state_r <= hscs_pkg::HSCS_ST_HOLD;
          core_rst_n_r <= 1'b0;
        end
      endcase
    end
  end

  // pins are only caught in the sample state, while both shared pins still float as inputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      src_r <= 2'h0;
      strap_r <= 2'h0;
      cfg_done_r <= 1'b0;
    end else if (state_r == hscs_pkg::HSCS_ST_HOLD) begin
      cfg_done_r <= 1'b0;
    end else if (state_r == hscs_pkg::HSCS_ST_SAMPLE) begin
      src_r <= {cfg_source_sel_hi_in, cfg_source_sel_lo};
      strap_r <= {fixed_port_strap_hi, activity_led_in};
      cfg_done_r <= 1'b1;
    end
  end

  // local power sense, read only while the shared pin is not driven
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      self_power_r <= 1'b0;
    end else if (!act_oe_r) begin
      self_power_r <= activity_led_in;
    end
  end

  // mode decode from the latched select
  always_comb begin
    straps_en_nxt = src_uses_straps(src_r);
    fixed_nxt = straps_en_nxt ? strap_fixed(strap_r) : ports_r;
    act_low_nxt = straps_en_nxt ? strap_r[0] : ctrl_r[hscs_pkg::CTRL_LED_ACT_LOW];
    bus_powered_nxt = (src_r == hscs_pkg::SRC_DEFAULT_BUSPWR) || !self_power_r;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      straps_en_r <= 1'b0;
      smbus_en_r <= 1'b0;
      eeprom_en_r <= 1'b0;
      bus_powered_r <= 1'b1;
      fixed_r <= 2'h0;
    end else if (!cfg_done_r) begin
      straps_en_r <= 1'b0;
      smbus_en_r <= 1'b0;
      eeprom_en_r <= 1'b0;
      bus_powered_r <= 1'b1;
      fixed_r <= 2'h0;
    end else begin
      straps_en_r <= straps_en_nxt;
      smbus_en_r <= (src_r == hscs_pkg::SRC_SMBUS);
      eeprom_en_r <= (src_r == hscs_pkg::SRC_EEPROM);
      bus_powered_r <= bus_powered_nxt;
      fixed_r <= fixed_nxt;
    end
  end

  // indicator pins stay released until the straps have been caught
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      act_led_r <= 1'b0;
      act_oe_r <= 1'b0;
      hs_led_r <= 1'b0;
      hs_oe_r <= 1'b0;
    end else if (!cfg_done_r) begin
      act_led_r <= 1'b0;
      act_oe_r <= 1'b0;
      hs_led_r <= 1'b0;
      hs_oe_r <= 1'b0;
    end else begin
      act_led_r <= (ctrl_r[hscs_pkg::CTRL_CONFIGURED] && !ctrl_r[hscs_pkg::CTRL_SUSPENDED])
                   ^ act_low_nxt;
      act_oe_r <= ctrl_r[hscs_pkg::CTRL_LED_DRIVE];
      hs_led_r <= ctrl_r[hscs_pkg::CTRL_HIGH_SPEED] ^ src_r[1];
      hs_oe_r <= 1'b1;
    end
  end

  // apb: answer in the first access cycle, no wait states
  assign setup_w = psel && !penable;
  assign access_w = psel && penable && pready_r;

  always_comb begin
    status_w = 32'h0000_0000;
    status_w[hscs_pkg::STAT_SRC_LSB +: 2] = src_r;
    status_w[hscs_pkg::STAT_STRAP_LSB +: 2] = strap_r;
    status_w[hscs_pkg::STAT_STRAPS_EN] = straps_en_r;
    status_w[hscs_pkg::STAT_BUS_POWERED] = bus_powered_r;
    status_w[hscs_pkg::STAT_SELF_POWER] = self_power_r;
    status_w[hscs_pkg::STAT_FIXED_LSB +: 2] = fixed_r;
    status_w[hscs_pkg::STAT_CFG_DONE] = cfg_done_r;
    status_w[hscs_pkg::STAT_SMB_ADDR_LSB +: 7] = hscs_pkg::SMBUS_SLAVE_ADDR;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (setup_w) begin
      pready_r <= 1'b1;
      pslverr_r <= 1'b1;
      prdata_r <= 32'h0000_0000;
      case (paddr)
        hscs_pkg::ADDR_CTRL: begin
          pslverr_r <= 1'b0;
          prdata_r <= {27'h0, ctrl_r};
        end
        hscs_pkg::ADDR_PORTS: begin
          pslverr_r <= 1'b0;
          prdata_r <= {30'h0, ports_r};
        end
        hscs_pkg::ADDR_STATUS: begin
          // status is read only; a write is refused
          pslverr_r <= pwrite;
          prdata_r <= status_w;
        end
        default: begin
          pslverr_r <= 1'b1;
        end
      endcase
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= hscs_pkg::CTRL_RESET;
      ports_r <= hscs_pkg::PORTS_RESET;
    end else if (!core_rst_n_r) begin
      ctrl_r <= hscs_pkg::CTRL_RESET;
      ports_r <= hscs_pkg::PORTS_RESET;
    end else if (access_w && pwrite) begin
      if (paddr == hscs_pkg::ADDR_CTRL) begin
        ctrl_r <= pwdata[hscs_pkg::CTRL_W-1:0];
      end
      if (paddr == hscs_pkg::ADDR_PORTS) begin
        ports_r <= pwdata[hscs_pkg::PORTS_W-1:0];
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign high_speed_led_out = hs_led_r;
  assign high_speed_led_oe = hs_oe_r;
  assign activity_led_out = act_led_r;
  assign activity_led_oe = act_oe_r;
  assign core_rst_n = core_rst_n_r;
  assign cfg_done = cfg_done_r;
  assign cfg_source = src_r;
  assign straps_en = straps_en_r;
  assign smbus_slave_en = smbus_en_r;
  assign eeprom_load_en = eeprom_en_r;
  assign bus_powered = bus_powered_r;
  assign self_power = self_power_r;
  assign fixed_ports = fixed_r;

  // fixed address, held in a flop so every output leaves a register
  logic [6:0] smb_addr_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      smb_addr_r <= 7'h00;
    end else begin
      // address rises with the enable, never a cycle behind it
      smb_addr_r <= (cfg_done_r && (src_r == hscs_pkg::SRC_SMBUS)) ?
                    hscs_pkg::SMBUS_SLAVE_ADDR : 7'h00;
    end
  end
  assign smbus_slave_addr = smb_addr_r;

endmodule // hscs_top

/* verification/hscs_top_sva.sv */
// Purpose: port checks for hscs_top
// Assumes: one clk domain, nrst async active low
// Notes: mode outputs are judged one edge after cfg_done
`timescale 1ns/1ps
module hscs_top_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic supply_good,
  input wire logic core_rst_n,
  input wire logic cfg_done,
  input wire logic [1:0] cfg_source,
  input wire logic straps_en,
  input wire logic smbus_slave_en,
  input wire logic [6:0] smbus_slave_addr,
  input wire logic eeprom_load_en,
  input wire logic bus_powered,
  input wire logic self_power,
  input wire logic high_speed_led_oe
);
  logic done_r;
  logic v;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= cfg_done;
    end
  end
  // mode outputs lag cfg_done by one edge
  assign v = cfg_done && done_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_por; !supply_good |-> ##[1:2] (!core_rst_n && !cfg_done); endproperty
  a_por: assert property (p_por) else $error("core left running");
  property p_src; v |-> $stable(cfg_source); endproperty
  a_src: assert property (p_src) else $error("source moved");
  property p_dflt; v && cfg_source == 2'h0 |-> straps_en && !eeprom_load_en; endproperty
  a_dflt: assert property (p_dflt) else $error("default mode");
  property p_bus; v && cfg_source == 2'h2 |-> straps_en && bus_powered; endproperty
  a_bus: assert property (p_bus) else $error("bus power mode");
  property p_smb; v |-> smbus_slave_en == (cfg_source == 2'h1) &&
    smbus_slave_addr == ((cfg_source == 2'h1) ? 7'h2c : 7'h00); endproperty
  a_smb: assert property (p_smb) else $error("slave mode");
  property p_eep; v && cfg_source[0] |-> !straps_en && eeprom_load_en == cfg_source[1];
  endproperty
  a_eep: assert property (p_eep) else $error("eeprom mode");
  property p_pwr; v && $stable(self_power) && $past(self_power, 2) == self_power |->
    bus_powered == (cfg_source == 2'h2 || !self_power); endproperty
  a_pwr: assert property (p_pwr) else $error("power sense");
  property p_hsoe; !cfg_done |-> ##[0:1] !high_speed_led_oe; endproperty
  a_hsoe: assert property (p_hsoe) else $error("led driven early");
endmodule // hscs_top_sva
bind hscs_top hscs_top_sva i_hscs_top_sva (.clk(clk), .nrst(nrst),
  .supply_good(supply_good), .core_rst_n(core_rst_n), .cfg_done(cfg_done),
  .cfg_source(cfg_source), .straps_en(straps_en), .smbus_slave_en(smbus_slave_en),
  .smbus_slave_addr(smbus_slave_addr), .eeprom_load_en(eeprom_load_en),
  .bus_powered(bus_powered), .self_power(self_power), .high_speed_led_oe(high_speed_led_oe));

/* verification/hscs_board.sv */
// Purpose: board straps, reset source and shared pin wiring
// Assumes: bench sets strap and select knobs before pulsing go
// Notes: strap resistor shows on the shared pin until the sense source takes over
`timescale 1ns/1ps
module hscs_board (
  input wire logic clk,
  input wire logic go,
  input wire logic por_ok,
  input wire logic cfg_done,
  input wire logic [1:0] sel,
  input wire logic [1:0] strap,
  input wire logic sense,
  input wire logic led_out,
  input wire logic led_oe,
  input wire logic hs_out,
  input wire logic hs_oe,
  output logic nrst,
  output logic supply_good,
  output logic sel_lo,
  output logic sel_hi,
  output logic act_pin,
  output logic strap_hi
);
  logic [7:0] cnt_r = 8'h03;
  always @(posedge clk) begin
    cnt_r <= go ? 8'hc8 : cnt_r - {7'h00, cnt_r != 8'h00};
  end
  assign nrst = (cnt_r == 8'h00);
  assign supply_good = por_ok;
  assign sel_lo = sel[0];
  assign strap_hi = strap[1];
  assign sel_hi = hs_oe ? hs_out : sel[1];
  assign act_pin = led_oe ? led_out : (cfg_done ? sense : strap[0]);
endmodule // hscs_board

/* verification/tb_top.sv */
// Purpose: self-checking bench for hscs_top
// Assumes: board model supplies reset, straps and pin levels
// Notes: every select and strap pair is booted once in the 16-pass loop
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic go = 1'b0, por_ok = 1'b1, sense = 1'b0, er;
  logic [1:0] sel = 2'h0, strap = 2'h0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, seed = 32'h496d4fce, prdata;
  int miscompares = 0, checks_done = 0;
  logic nrst, supply_good, sel_lo, sel_hi, act_pin, strap_hi, pready, pslverr;
  logic hs_out, hs_oe, led_out, led_oe, core_rst_n, cfg_done, straps_en;
  logic smb_en, eep, bus_powered, self_power;
  logic [1:0] cfg_source, fixed_ports;
  logic [6:0] smb_addr;
  always #2.5 clk = ~clk;
  hscs_board i_hscs_board (.clk(clk), .go(go), .por_ok(por_ok), .cfg_done(cfg_done),
    .sel(sel), .strap(strap), .sense(sense), .led_out(led_out), .led_oe(led_oe),
    .hs_out(hs_out), .hs_oe(hs_oe), .nrst(nrst), .supply_good(supply_good),
    .sel_lo(sel_lo), .sel_hi(sel_hi), .act_pin(act_pin), .strap_hi(strap_hi));
  hscs_top i_hscs_top (.clk(clk), .nrst(nrst), .supply_good(supply_good), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfg_source_sel_lo(sel_lo),
    .cfg_source_sel_hi_in(sel_hi), .high_speed_led_out(hs_out), .high_speed_led_oe(hs_oe),
    .activity_led_in(act_pin), .activity_led_out(led_out), .activity_led_oe(led_oe),
    .fixed_port_strap_hi(strap_hi), .core_rst_n(core_rst_n), .cfg_done(cfg_done),
    .cfg_source(cfg_source), .straps_en(straps_en), .smbus_slave_en(smb_en),
    .smbus_slave_addr(smb_addr), .eeprom_load_en(eep), .bus_powered(bus_powered),
    .self_power(self_power), .fixed_ports(fixed_ports));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [1:0] fix_exp(input logic [1:0] t);
    return (t == 2'h0) ? 2'h0 : (t == 2'h1) ? 2'h1 : 2'h3;
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) miscompares++;
  endtask
  task wait_done;
    int n;
    n = 0;
    while (cfg_done !== 1'b1 && n < 600) begin
      @(posedge clk);
      n++;
    end
    if (n >= 600) miscompares++;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    logic [1:0] s;
    logic [1:0] t;
    repeat (4) @(posedge clk);
    wait_done;
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      s = i[3:2];
      t = i[1:0];
      @(posedge clk);
      sel <= s;
      strap <= t;
      sense <= seed[5];
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      wait_done;
      chk("cfg_source", s, cfg_source);
      apb(1'b1, 8'h04, {30'h0, seed[1:0]});
      apb(1'b1, 8'h00, {27'h0, seed[4], 1'b1, seed[2:0]});
      // sense moves while the pin is driven; the core must not follow it
      sense <= seed[6];
      repeat (2) @(posedge clk);
      chk("fixed_ports", s[0] ? seed[1:0] : fix_exp(t), fixed_ports);
      chk("activity", (seed[0] & ~seed[1]) ^ (s[0] ? seed[4] : t[0]), led_out);
      chk("activity_oe", 1'b1, led_oe);
      chk("high_speed", seed[2] ^ s[1], hs_out);
      chk("high_speed_oe", 1'b1, hs_oe);
      chk("self_power_held", seed[5], self_power);
      // shared pin released so the sense level reaches the core
      apb(1'b1, 8'h00, 32'h0);
      repeat (4) @(posedge clk);
      chk("activity_oe", 1'b0, led_oe);
      chk("self_power", seed[6], self_power);
      chk("bus_powered", s == 2'h2 || !seed[6], bus_powered);
      apb(1'b0, 8'h08, 32'h0);
      chk("status_straps", !s[0], rd[4]);
      chk("status_src", s, rd[1:0]);
      apb(1'b0, 8'h04, 32'h0);
      chk("ports_rd", {30'h0, seed[1:0]}, rd);
      chk("ports_err", 1'b0, er);
      apb(1'b1, 8'h08, 32'hffff_ffff);
      chk("status_wr_err", 1'b1, er);
      apb(1'b0, {seed[9:6], 4'hc}, 32'h0);
      chk("unmapped_err", 1'b1, er);
      chk("unmapped_rd", 32'h0, rd);
    end
    por_ok <= 1'b0;
    repeat (4) @(posedge clk);
    chk("core_rst_n", 1'b0, core_rst_n);
    chk("cfg_done", 1'b0, cfg_done);
    por_ok <= 1'b1;
    wait_done;
    chk("cfg_source", 2'h3, cfg_source);
    wrap_up;
  end
  initial begin
    #100000;
    miscompares++;
    wrap_up;
  end
endmodule // tb_top
